// [wdt_pkg.sv]
// shared constants and types for the watchdog block
// assumes a single 40 MHz system clock and an AHB-Lite register port
package wdt_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] CMD_OFS = 8'h08;
	localparam logic [7:0] CNT_OFS = 8'h0C;

	// ----------------------------------------
	// field layout
	// ----------------------------------------
	localparam int SWEN_BIT = 0;
	localparam int PSEL_LSB = 1;
	localparam int PSEL_MSB = 5;
	localparam int STAT_TO_BIT = 0;
	localparam int STAT_PD_BIT = 1;
	localparam int STAT_SLEEP_BIT = 2;
	localparam int STAT_WAKING_BIT = 3;
	localparam int CMD_CLR_BIT = 0;

	// ----------------------------------------
	// reset values and encodings
	// ----------------------------------------
	localparam logic [4:0] PSEL_RST = 5'h0B;
	localparam logic SWEN_RST = 1'b0;
	localparam logic [4:0] PSEL_MAX = 5'h12;
	localparam logic [4:0] PSCL_MIN_LOG2 = 5'h05;
	localparam int CNT_W = 23;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SW = 2'h1;
	localparam logic [1:0] MODE_NO_SLEEP = 2'h2;
	localparam logic [1:0] MODE_ON = 2'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum {PWR_AWAKE, PWR_ASLEEP, PWR_WAKING} pwr_state_t;

endpackage

// [wdt_cnt_if.sv]
// carrier between the watchdog control logic and its counter
// assumes both ends run on mclk
`timescale 1ns/100ps
interface wdt_cnt_if;
	logic clear;
	logic tick;
	logic [4:0] period_sel;
	logic expire;
	logic [22:0] count;

	modport ctl (output clear, output tick, output period_sel, input expire, input count);
	modport cnt (input clear, input tick, input period_sel, output expire, output count);
endinterface

// [wdt_counter.sv]
// 23-bit watchdog counter advanced by low-frequency oscillator ticks
// assumes tick is a one-cycle pulse synchronous to mclk
`timescale 1ns/100ps
module wdt_counter import wdt_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control side
	wdt_cnt_if.cnt cif
);

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] limit;
	logic [CNT_W:0] ratio;
	logic [4:0] sel;

	// ----------------------------------------
	// prescale limit
	// ----------------------------------------
	always_comb begin
		// reserved codes fall back to the shortest interval
		sel = (cif.period_sel > PSEL_MAX) ? 5'h00 : cif.period_sel;
		ratio = 24'h000001 << (PSCL_MIN_LOG2 + sel);
		limit = CNT_W'(ratio - 24'h000001);
	end

	assign cif.expire = cif.tick && !cif.clear && (cnt_r == limit);
	assign cif.count = cnt_r;

	// ----------------------------------------
	// count
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst || cif.clear) begin
			cnt_r <= '0;
		end else if (cif.tick) begin
			if (cif.expire) begin
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + 23'h000001;
			end
		end
	end

endmodule

// [watchdog_timer.sv]
// watchdog timer with sleep-aware operating modes, AHB-Lite register port
// assumes lf_osc_tick pulses once per low-frequency oscillator period,
// all inputs synchronous to mclk, and a single AHB-Lite master
`timescale 1ns/100ps
module watchdog_timer import wdt_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// time base and configuration
	input wire logic lf_osc_tick,
	input wire logic [1:0] watchdog_mode_cfg,
	// core and clock system events
	input wire logic watchdog_clear_instr,
	input wire logic sleep_instr,
	input wire logic wake_event,
	input wire logic osc_fail,
	input wire logic osc_startup_timer_run,
	input wire logic sysclk_is_crystal,
	// results
	output logic wdt_reset_req,
	output logic wdt_wake,
	output logic asleep,
	output logic timeout_flag,
	output logic powerdown_flag
);

	wdt_cnt_if cif ();

	wdt_counter u_counter (
		.mclk(mclk),
		.rst(rst),
		.cif(cif)
	);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [4:0] period_sel_r;
	logic sw_en_r;
	logic timeout_flag_r;
	logic powerdown_flag_r;
	logic wdt_reset_req_r;
	logic wdt_wake_r;
	logic [31:0] hrdata_r;
	logic dph_wr_r;
	logic dph_rd_r;
	logic rd_ok_r;
	logic [7:0] dph_addr_r;
	pwr_state_t state_r;
	pwr_state_t state_nxt;
	logic addr_ok;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_cmd;
	logic sw_clear;
	logic in_sleep;
	logic active;
	logic sleep_enter;
	logic sleep_exit;
	logic expire_awake;
	logic expire_sleep;
	logic [31:0] rd_mux;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// only whole-word transfers are accepted; others complete with no effect
	assign addr_ok = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
	assign hreadyout = !dph_rd_r || rd_ok_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	assign wr_ctrl = dph_wr_r && (dph_addr_r == CTRL_OFS);
	assign wr_stat = dph_wr_r && (dph_addr_r == STAT_OFS);
	assign wr_cmd = dph_wr_r && (dph_addr_r == CMD_OFS);
	assign sw_clear = wr_cmd && hwdata[CMD_CLR_BIT];

	always_ff @(posedge mclk) begin
		if (rst) begin
			dph_wr_r <= 1'b0;
			dph_rd_r <= 1'b0;
			rd_ok_r <= 1'b0;
			dph_addr_r <= 8'h00;
		end else if (hreadyout) begin
			dph_wr_r <= addr_ok && hwrite;
			dph_rd_r <= addr_ok && !hwrite;
			dph_addr_r <= haddr[7:0];
			rd_ok_r <= 1'b0;
		end else begin
			rd_ok_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// reads take one wait state so a write just before is always seen
	always_comb begin
		rd_mux = 32'h00000000;
		case (dph_addr_r)
			CTRL_OFS: begin
				rd_mux[PSEL_MSB:PSEL_LSB] = period_sel_r;
				rd_mux[SWEN_BIT] = sw_en_r;
			end
			STAT_OFS: begin
				rd_mux[STAT_TO_BIT] = timeout_flag_r;
				rd_mux[STAT_PD_BIT] = powerdown_flag_r;
				rd_mux[STAT_SLEEP_BIT] = in_sleep;
				rd_mux[STAT_WAKING_BIT] = (state_r == PWR_WAKING);
			end
			CNT_OFS: begin
				rd_mux[CNT_W-1:0] = cif.count;
			end
			default: begin
				rd_mux = 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			hrdata_r <= 32'h00000000;
		end else if (dph_rd_r && !rd_ok_r) begin
			hrdata_r <= rd_mux;
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			period_sel_r <= PSEL_RST;
			sw_en_r <= SWEN_RST;
		end else if (wr_ctrl) begin
			period_sel_r <= hwdata[PSEL_MSB:PSEL_LSB];
			sw_en_r <= hwdata[SWEN_BIT];
		end
	end

	// ----------------------------------------
	// operating mode
	// ----------------------------------------
	assign in_sleep = (state_r == PWR_ASLEEP);

	always_comb begin
		case (watchdog_mode_cfg)
			MODE_ON: active = 1'b1;
			MODE_NO_SLEEP: active = !in_sleep;
			MODE_SW: active = sw_en_r;
			MODE_OFF: active = 1'b0;
			default: active = 1'b0;
		endcase
	end

	// ----------------------------------------
	// sleep sequencing
	// ----------------------------------------
	// a wake source already pending turns the sleep request into a no-op
	assign sleep_enter = (state_r == PWR_AWAKE) && sleep_instr && !wake_event;
	assign expire_awake = cif.expire && (state_r == PWR_AWAKE);
	assign expire_sleep = cif.expire && in_sleep;
	assign sleep_exit = in_sleep && (wake_event || expire_sleep);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PWR_AWAKE: begin
				if (sleep_enter) begin
					state_nxt = PWR_ASLEEP;
				end
			end
			PWR_ASLEEP: begin
				if (sleep_exit) begin
					// crystal clocks must wait out the start-up timer
					state_nxt = sysclk_is_crystal ? PWR_WAKING : PWR_AWAKE;
				end
			end
			PWR_WAKING: begin
				if (!osc_startup_timer_run) begin
					state_nxt = PWR_AWAKE;
				end
			end
			default: begin
				state_nxt = PWR_AWAKE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= PWR_AWAKE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign asleep = in_sleep;

	// ----------------------------------------
	// counter control
	// ----------------------------------------
	// the oscillator divider select has no path here, so retuning the
	// system clock never disturbs the count
	assign cif.tick = lf_osc_tick;
	assign cif.period_sel = period_sel_r;
	assign cif.clear = watchdog_clear_instr
		|| sw_clear
		|| sleep_enter
		// a time-out in sleep empties the count through its own expiry;
		// feeding sleep_exit back here would loop through expire
		|| (in_sleep && wake_event)
		|| osc_fail
		|| !active
		|| osc_startup_timer_run
		|| (state_r == PWR_WAKING);

	// ----------------------------------------
	// reset request and wake
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			wdt_reset_req_r <= 1'b0;
		end else begin
			wdt_reset_req_r <= expire_awake;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wdt_wake_r <= 1'b0;
		end else begin
			wdt_wake_r <= expire_sleep;
		end
	end

	assign wdt_reset_req = wdt_reset_req_r;
	assign wdt_wake = wdt_wake_r;

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	// write one to clear; a hardware set in the same cycle wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			timeout_flag_r <= 1'b0;
		end else if (expire_sleep) begin
			timeout_flag_r <= 1'b1;
		end else if (wr_stat && hwdata[STAT_TO_BIT]) begin
			timeout_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			powerdown_flag_r <= 1'b0;
		end else if (sleep_enter || expire_sleep) begin
			powerdown_flag_r <= 1'b1;
		end else if (wr_stat && hwdata[STAT_PD_BIT]) begin
			powerdown_flag_r <= 1'b0;
		end
	end

	assign timeout_flag = timeout_flag_r;
	assign powerdown_flag = powerdown_flag_r;

endmodule

// [wdt_core_model.sv]
// cpu core model: issues clear, sleep and wake pulses
// assumes the bench calls issue right after a rising edge
`timescale 1ns/100ps
module wdt_core_model (
	// clock
	input wire logic mclk,
	// core events
	output logic clear_instr,
	output logic sleep_instr,
	output logic wake_event
);
	initial begin
		clear_instr = 1'b0;
		sleep_instr = 1'b0;
		wake_event = 1'b0;
	end
	// slow delays the pulse by whole cycles, as a busy core would
	task automatic issue(input int kind, input int slow);
		repeat (slow) @(posedge mclk);
		case (kind)
			0: clear_instr <= 1'b1;
			1: sleep_instr <= 1'b1;
			default: wake_event <= 1'b1;
		endcase
		@(posedge mclk);
		clear_instr <= 1'b0;
		sleep_instr <= 1'b0;
		wake_event <= 1'b0;
	endtask
endmodule

// [watchdog_timer_assertions.sv]
// port checker for the watchdog block
// assumes it is bound to every watchdog_timer instance
`timescale 1ns/100ps
module watchdog_timer_assertions (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// events and results
	input wire logic [1:0] watchdog_mode_cfg,
	input wire logic sleep_instr,
	input wire logic wake_event,
	input wire logic osc_fail,
	input wire logic wdt_reset_req,
	input wire logic wdt_wake,
	input wire logic asleep,
	input wire logic timeout_flag,
	input wire logic powerdown_flag
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire take = hsel && hready && htrans[1] && hsize == 3'h2;
	a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
	a_sleep_entry: assert property (sleep_instr && !wake_event && !asleep |=> asleep && powerdown_flag)
		else $error("sleep entry missed");
	a_mode_off: assert property (watchdog_mode_cfg == 2'h0 [*2] |-> !wdt_reset_req && !wdt_wake)
		else $error("event while off");
	a_off_in_sleep: assert property (watchdog_mode_cfg == 2'h2 && asleep [*2] |-> !wdt_wake)
		else $error("wake in mode 10 sleep");
	a_no_sleep_reset: assert property (asleep [*2] |-> !wdt_reset_req)
		else $error("reset during sleep");
	a_fail_clears: assert property (osc_fail [*2] |-> !wdt_reset_req && !wdt_wake)
		else $error("event during osc fail");
	a_reset_pulse: assert property (wdt_reset_req |=> !wdt_reset_req)
		else $error("reset request too long");
	a_wake_flags: assert property (wdt_wake |=> timeout_flag && powerdown_flag)
		else $error("wake flags not set");
endmodule
bind watchdog_timer watchdog_timer_assertions chk (.mclk(mclk), .rst(rst), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .watchdog_mode_cfg(watchdog_mode_cfg), .sleep_instr(sleep_instr),
	.wake_event(wake_event), .osc_fail(osc_fail), .wdt_reset_req(wdt_reset_req),
	.wdt_wake(wdt_wake), .asleep(asleep), .timeout_flag(timeout_flag),
	.powerdown_flag(powerdown_flag));

// [watchdog_timer_with_sleep_modes_test.sv]
// self-checking bench for the watchdog block
// assumes the core model drives clear, sleep and wake
`timescale 1ns/100ps
module watchdog_timer_with_sleep_modes_test import wdt_pkg::*;;
	logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, tick = 1'b0;
	logic osc_fail = 1'b0, ost_run = 1'b0, xtal = 1'b0, rd_ph = 1'b0;
	logic [1:0] htrans = 2'h0, mode = 2'h3;
	logic [2:0] hsize = HSIZE_WORD;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic hreadyout, hresp, clr, slp, wake, rreq, wwake, asl, tof, pdf;
	int errors = 0, checks_done = 0, cyc = 0, seed = 36;
	logic [31:0] rd_q[$];
	logic [1:0] ev_q[$];
	always #12.5 mclk = ~mclk;
	watchdog_timer uut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .lf_osc_tick(tick), .watchdog_mode_cfg(mode),
		.watchdog_clear_instr(clr), .sleep_instr(slp), .wake_event(wake), .osc_fail(osc_fail),
		.osc_startup_timer_run(ost_run), .sysclk_is_crystal(xtal), .wdt_reset_req(rreq),
		.wdt_wake(wwake), .asleep(asl), .timeout_flag(tof), .powerdown_flag(pdf));
	wdt_core_model core (.mclk(mclk), .clear_instr(clr), .sleep_instr(slp), .wake_event(wake));
	// ----
	// tasks
	// ----
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		hsel <= 1'b1;
		hwrite <= wr;
		haddr <= {24'h0, a};
		if (!wr) rd_q.push_back(d);
		do @(posedge mclk); while (!hreadyout);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (!hreadyout);
	endtask
	// ev is noted just before the tick that should cause it
	task automatic ticks(input int n, input logic [1:0] ev);
		for (int i = 1; i <= n; i++) begin
			if (i == n && ev != 2'h0) ev_q.push_back(ev);
			tick <= 1'b1;
			@(posedge mclk);
			tick <= 1'b0;
			repeat (1 + $unsigned($random(seed)) % 4) @(posedge mclk);
		end
		repeat (3) @(posedge mclk);
	endtask
	task automatic end_of_test();
		// an expected result that never showed up is a mismatch too
		cmp("pending", 32'h0, 32'(ev_q.size() + rd_q.size()));
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ----
	// monitor and timeout
	// ----
	always @(posedge mclk) begin
		cyc++;
		if (rd_ph && hreadyout) cmp("register", rd_q.pop_front(), hrdata);
		if (!rst && (rreq || wwake))
			cmp("event", {30'h0, ev_q.size() ? ev_q.pop_front() : 2'h0}, {30'h0, wwake, rreq});
		if (hreadyout) rd_ph = hsel && htrans[1] && !hwrite;
		if (cyc == 40000) begin
			errors++;
			end_of_test();
		end
	end
	// ----
	// scenarios
	// ----
	initial begin
		int s;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		bus(0, CTRL_OFS, 32'h16);
		bus(0, STAT_OFS, 32'h0);
		bus(0, 8'h10, 32'h0);
		bus(1, CTRL_OFS, 32'hFFFFFFFF);
		bus(0, CTRL_OFS, 32'h3F);
		$display("registers done");
		for (int m = 0; m < 8; m++) begin
			mode <= m[2:1];
			bus(1, CTRL_OFS, {31'h0, m[0]});
			core.issue(0, m % 2);
			ticks(32, m >= 3 ? 2'h1 : 2'h0);
		end
		ticks(31, 2'h0);
		bus(0, CNT_OFS, 32'h0000001F);
		core.issue(0, 0);
		ticks(31, 2'h0);
		bus(1, CMD_OFS, 32'h1);
		ticks(20, 2'h0);
		osc_fail <= 1'b1;
		repeat (3) @(posedge mclk);
		osc_fail <= 1'b0;
		ticks(32, 2'h1);
		bus(1, CTRL_OFS, 32'h26);
		ticks(32, 2'h1);
		for (int k = 0; k < 3; k++) begin
			s = $unsigned($random(seed)) % 4;
			bus(1, CTRL_OFS, 32'(s << 1));
			ticks(32 << s, 2'h1);
		end
		// the sleep tests below count on the shortest period again
		bus(1, CTRL_OFS, 32'h00000000);
		$display("modes and periods done");
		core.issue(1, 1);
		bus(0, STAT_OFS, 32'h6);
		ticks(32, 2'h2);
		bus(0, STAT_OFS, 32'h3);
		bus(1, STAT_OFS, 32'h3);
		bus(0, STAT_OFS, 32'h0);
		mode <= 2'h2;
		core.issue(1, 0);
		ticks(40, 2'h0);
		core.issue(2, 1);
		ticks(32, 2'h1);
		mode <= 2'h3;
		xtal <= 1'b1;
		core.issue(1, 0);
		ost_run <= 1'b1;
		core.issue(2, 0);
		bus(0, STAT_OFS, 32'hA);
		ticks(40, 2'h0);
		ost_run <= 1'b0;
		// the waking state still holds the count clear for one more edge
		@(posedge mclk);
		ticks(32, 2'h1);
		$display("sleep done");
		end_of_test();
	end
endmodule
